// [hdl/cmp_ctl_pkg.sv]
// Package with register map, field positions and reset values of the block
package cmp_ctl_pkg;

    // ************************************************************
    // Register byte offsets on the Avalon-MM slave
    // ************************************************************
    localparam logic [4:0] OFS_CTL      = 5'h00; // comparator_control
    localparam logic [4:0] OFS_FLAG     = 5'h04; // periph_flag_reg
    localparam logic [4:0] OFS_IRQ_EN   = 5'h08; // irq enables
    localparam logic [4:0] OFS_STATUS   = 5'h0C; // sticky event status
    localparam logic [4:0] OFS_MASK     = 5'h10; // status mask

    // ************************************************************
    // Fields of comparator_control
    // ************************************************************
    localparam int CTL_ON_BIT     = 7; // comparator_on
    localparam int CTL_RESULT_BIT = 6; // compare_result, read only
    localparam int CTL_PIN_BIT    = 5; // result_pin_drive
    localparam int CTL_INV_BIT    = 4; // result_invert
    localparam int CTL_REF_BIT    = 2; // noninv_ref_select
    localparam int CTL_CHAN_BIT   = 0; // inverting_channel_select
    localparam logic [7:0] CTL_WR_MASK = 8'hB5; // Writable bits
    localparam logic [7:0] CTL_RESET   = 8'h00; // All bits clear

    // ************************************************************
    // Fields of the flag, enable, status and mask registers
    // ************************************************************
    localparam int FLAG_CHANGE_BIT = 0; // compare_change_flag
    localparam int EN_CHANGE_BIT   = 0; // compare_change_irq_en
    localparam int EN_PERIPH_BIT   = 1; // peripheral_irq_en
    localparam int EN_GLOBAL_BIT   = 2; // global_irq_en
    localparam int ST_CHANGE_BIT   = 0; // Change flag rose
    localparam int ST_WAKE_BIT     = 1; // Wake request rose
    localparam int ST_WIDTH        = 2; // Status and mask width
    localparam logic [2:0]          IRQ_EN_RESET = 3'h0;
    localparam logic [ST_WIDTH-1:0] STATUS_RESET = 2'h0;
    localparam logic [ST_WIDTH-1:0] MASK_RESET   = 2'h0;

endpackage

// [hdl/cmp_sync2.sv]
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module cmp_sync2
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Asynchronous level in, synchronised level out
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_q; // First stage, read only by the second

    // ************************************************************
    // Two stages
    // ************************************************************
    // Shift the level through both stages
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_q   <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// [hdl/comparator_control_and_wake.sv]
// Comparator control register, change flag, interrupt and wake logic
//
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps

// Function
// - Change during register read may skip flag
// - Enabled comparator keeps evaluating during sleep
// - Clearing comparator_on powers comparator down
// - Result change wakes when both enables set
// - Vector on change flag, both enables and global enable, asleep or not
// - Reset leaves comparator and reference off
// - result_pin_drive routes result to pin
// - compare_result follows inputs and polarity
// - result_invert inverts comparison result
// - noninv_ref_select picks internal reference input
// - inverting_channel_select picks inverting input pin
// - Pin driven only when all three set
// - Bits 3,1 read zero, reset zero
// - Read latch and per-cycle latch form mismatch
// - Flag set on mismatch rising edge
// - Write zero clears flag, one sets
// - Control write also refreshes read latch
module comparator_control_and_wake
    import cmp_ctl_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Analog comparator side
    input  wire logic        raw_compare,
    output logic             comparator_power,
    output logic             noninv_ref_select,
    output logic             inverting_channel_select,
    // Port pin for the result
    input  wire logic        pin_direction,
    output logic             result_pin_out,
    output logic             result_pin_oe,
    // Core sleep and interrupt
    input  wire logic        sleep_active,
    output logic             wake_req,
    output logic             irq_vector_req,
    output logic             irq
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [7:0]          ctl_q;         // Writable control bits
    logic [7:0]          ctl_d;         // Next control value
    logic                flag_q;        // compare_change_flag
    logic                flag_d;        // Next flag value
    logic [2:0]          irq_en_q;      // Interrupt enables
    logic [ST_WIDTH-1:0] status_q;      // Sticky events
    logic [ST_WIDTH-1:0] status_d;      // Next sticky events
    logic [ST_WIDTH-1:0] mask_q;        // Status mask
    logic                ack_q;         // Second cycle of a request
    logic [31:0]         rdata_q;       // Registered read data
    logic                cycle_latch_q; // Result taken every cycle
    logic                read_latch_q;  // Result taken on control read or write
    logic                mismatch_q;    // Mismatch one cycle ago
    logic                wake_q;        // Wake request one cycle ago
    logic                raw_sync;      // Synchronised raw result
    wire                 request;       // Read or write pending
    wire                 accept;        // Edge where request completes
    wire                 lane0;         // Low byte enabled
    wire                 sel_ctl;       // Address decodes
    wire                 sel_flag;
    wire                 sel_en;
    wire                 sel_status;
    wire                 sel_mask;
    wire                 wr_ctl;        // Accepted writes
    wire                 wr_flag;
    wire                 wr_en;
    wire                 wr_status;
    wire                 wr_mask;
    wire                 ctl_access;    // Read or write of control
    wire                 result_now;    // Polarity corrected result
    wire                 mismatch;      // Latches disagree
    wire                 change_set;    // Rising edge of mismatch
    wire                 wake_cond;     // Flag and both enables set
    wire [7:0]           ctl_view;      // Control as software reads it
    wire [31:0]          rdata_mux;     // Selected read word

    // ************************************************************
    // Input synchroniser
    // ************************************************************
    // Raw result comes from the analog stage with no clock
    cmp_sync2 u_raw_sync
    (
        .clk      (clk),
        .rst      (rst),
        .async_in (raw_compare),
        .sync_out (raw_sync)
    );

    // ************************************************************
    // Bus decode
    // ************************************************************
    assign request    = avs_read | avs_write;
    assign accept     = request & ack_q;
    assign lane0      = avs_byteenable[0];
    assign sel_ctl    = (avs_address == OFS_CTL);
    assign sel_flag   = (avs_address == OFS_FLAG);
    assign sel_en     = (avs_address == OFS_IRQ_EN);
    assign sel_status = (avs_address == OFS_STATUS);
    assign sel_mask   = (avs_address == OFS_MASK);
    assign wr_ctl     = accept & avs_write & lane0 & sel_ctl;
    assign wr_flag    = accept & avs_write & lane0 & sel_flag;
    assign wr_en      = accept & avs_write & lane0 & sel_en;
    assign wr_status  = accept & avs_write & lane0 & sel_status;
    assign wr_mask    = accept & avs_write & lane0 & sel_mask;
    // A write starts with an implicit read of the control register
    assign ctl_access = accept & sel_ctl;

    // Hold the master one cycle, then complete
    assign avs_waitrequest = request & ~ack_q;
    assign avs_readdata    = rdata_q;

    // ************************************************************
    // Comparator result path
    // ************************************************************
    // Powered off comparator reports low; polarity swaps the sense
    assign result_now = ctl_q[CTL_ON_BIT] &
                        (raw_sync ^ ctl_q[CTL_INV_BIT]);
    assign mismatch   = cycle_latch_q ^ read_latch_q;
    assign change_set = mismatch & ~mismatch_q;

    // Analog controls follow the control bits
    assign comparator_power         = ctl_q[CTL_ON_BIT];
    assign noninv_ref_select        = ctl_q[CTL_REF_BIT];
    assign inverting_channel_select = ctl_q[CTL_CHAN_BIT];

    // Pin drive needs output enable, power and pin set as output
    assign result_pin_oe  = ctl_q[CTL_PIN_BIT] & ctl_q[CTL_ON_BIT] &
                            ~pin_direction;
    assign result_pin_out = cycle_latch_q;

    // ************************************************************
    // Wake and interrupt requests
    // ************************************************************
    assign wake_cond      = flag_q & irq_en_q[EN_CHANGE_BIT] &
                            irq_en_q[EN_PERIPH_BIT];
    assign wake_req       = wake_cond & sleep_active;
    // Core runs the next instruction first, then vectors on this
    assign irq_vector_req = wake_cond & irq_en_q[EN_GLOBAL_BIT];
    assign irq            = |(status_q & mask_q);

    // ************************************************************
    // Read view
    // ************************************************************
    // Unimplemented bits 3 and 1 read as zero
    assign ctl_view = (ctl_q & CTL_WR_MASK) |
                      ({7'h00, cycle_latch_q} << CTL_RESULT_BIT);
    assign rdata_mux =
        sel_ctl    ? {24'h000000, ctl_view} :
        sel_flag   ? {31'h00000000, flag_q} :
        sel_en     ? {29'h00000000, irq_en_q} :
        sel_status ? {30'h00000000, status_q} :
        sel_mask   ? {30'h00000000, mask_q} :
                     32'h00000000;

    // ************************************************************
    // Next values
    // ************************************************************
    // Control register keeps only writable bits
    always_comb
    begin
        ctl_d = ctl_q;
        if (wr_ctl)
        begin
            ctl_d = avs_writedata[7:0] & CTL_WR_MASK;
        end
    end

    // Change flag: hardware set beats software clear
    always_comb
    begin
        flag_d = flag_q;
        if (wr_flag)
        begin
            flag_d = avs_writedata[FLAG_CHANGE_BIT];
        end
        if (change_set)
        begin
            flag_d = 1'b1;
        end
    end

    // Sticky status: events set, writing one clears, set wins
    always_comb
    begin
        status_d = status_q;
        if (wr_status)
        begin
            status_d = status_q & ~avs_writedata[ST_WIDTH-1:0];
        end
        if (change_set)
        begin
            status_d[ST_CHANGE_BIT] = 1'b1;
        end
        if (wake_req & ~wake_q)
        begin
            status_d[ST_WAKE_BIT] = 1'b1;
        end
    end

    // ************************************************************
    // Bus handshake
    // ************************************************************
    // First cycle captures read data, second completes
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            ack_q <= request & ~ack_q;
            if (request & ~ack_q)
            begin
                rdata_q <= rdata_mux;
            end
        end
    end

    // ************************************************************
    // Control and interrupt registers
    // ************************************************************
    // Reset leaves comparator and all enables off
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctl_q    <= CTL_RESET;
            flag_q   <= 1'b0;
            irq_en_q <= IRQ_EN_RESET;
            status_q <= STATUS_RESET;
            mask_q   <= MASK_RESET;
        end
        else
        begin
            ctl_q    <= ctl_d;
            flag_q   <= flag_d;
            status_q <= status_d;
            if (wr_en)
            begin
                irq_en_q <= avs_writedata[2:0];
            end
            if (wr_mask)
            begin
                mask_q <= avs_writedata[ST_WIDTH-1:0];
            end
        end
    end

    // ************************************************************
    // Mismatch latches
    // ************************************************************
    // Per-cycle latch and read latch; a change in the read cycle
    // lands in both, so no mismatch and no flag results
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cycle_latch_q <= 1'b0;
            read_latch_q  <= 1'b0;
            mismatch_q    <= 1'b0;
            wake_q        <= 1'b0;
        end
        else
        begin
            cycle_latch_q <= result_now;
            if (ctl_access)
            begin
                read_latch_q <= result_now;
            end
            mismatch_q <= mismatch;
            wake_q     <= wake_req;
        end
    end

endmodule

// [test/cmp_analog_model.sv]
// Behavioural analog front end that produces the raw comparison
`timescale 1ns/1ps
module cmp_analog_model
(
    // Input selections from the block
    input wire logic noninv_ref_select,
    input wire logic inverting_channel_select,
    // Analog levels in millivolts
    input var int    ext_pos,
    input var int    ref_level,
    input var int    neg_pin0,
    input var int    neg_pin1,
    // Raw result, keeps comparing even when powered off
    output logic     raw_compare
);
    // Levels at the two comparator inputs
    int pos_in;
    int neg_in;
    // Input multiplexers and the comparison
    always_comb
    begin
        pos_in = noninv_ref_select ? ref_level : ext_pos;
        neg_in = inverting_channel_select ? neg_pin1 : neg_pin0;
        raw_compare = pos_in > neg_in;
    end
endmodule

// [test/cmp_ctl_properties.sv]
// Concurrent checks on the ports of the comparator control block
`timescale 1ns/1ps
module cmp_ctl_properties
    import cmp_ctl_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Register bus
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Comparator, pin and core side
    input wire logic        comparator_power,
    input wire logic        noninv_ref_select,
    input wire logic        inverting_channel_select,
    input wire logic        pin_direction,
    input wire logic        result_pin_out,
    input wire logic        result_pin_oe,
    input wire logic        sleep_active,
    input wire logic        wake_req
);
    // ************************************************************
    // Clocking, sequences and assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Request in its first, waiting cycle
    sequence req_first;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    // Control register read at its completing edge
    sequence ctl_done;
        avs_read && !avs_waitrequest && avs_address == OFS_CTL;
    endsequence
    a_wait_one: assert property (req_first |=> !avs_waitrequest)
        else $error("request waited more than one cycle");
    a_ctl_fields: assert property (ctl_done |-> avs_readdata[3:0] ==
        {1'b0, noninv_ref_select, 1'b0, inverting_channel_select}
        && avs_readdata[7] == comparator_power)
        else $error("control fields read back wrong");
    a_result_bit: assert property (ctl_done |->
        avs_readdata[6] == $past(result_pin_out))
        else $error("result bit differs from latched result");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest
        && avs_address > OFS_MASK |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_pin_enable: assert property (result_pin_oe |->
        comparator_power && !pin_direction)
        else $error("pin driven without its conditions");
    a_off_result_low: assert property (!comparator_power |=>
        !result_pin_out)
        else $error("result high while comparator off");
    a_wake_sleep: assert property (wake_req |-> sleep_active)
        else $error("wake request outside sleep");
    a_reset_off: assert property (disable iff (1'b0) rst |=>
        !comparator_power && !result_pin_oe)
        else $error("comparator on after reset");
endmodule
bind comparator_control_and_wake cmp_ctl_properties chk_i (
    .clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .comparator_power(comparator_power),
    .noninv_ref_select(noninv_ref_select),
    .inverting_channel_select(inverting_channel_select),
    .pin_direction(pin_direction), .result_pin_out(result_pin_out),
    .result_pin_oe(result_pin_oe), .sleep_active(sleep_active),
    .wake_req(wake_req));

// [test/tb.sv]
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
module tb
    import cmp_ctl_pkg::*;
;
    // Clock, reset and register bus
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [31:0] q;
    // Comparator, pin and core side
    logic        raw_compare, comparator_power, noninv_ref_select;
    logic        inverting_channel_select, result_pin_out, result_pin_oe;
    logic        wake_req, irq_vector_req, irq;
    logic        pin_direction = 1'b0;
    logic        sleep_active = 1'b0;
    int          ext_pos = 30, ref_level = 10, neg_pin0 = 5, neg_pin1 = 20;
    int          n_errors = 0, checks = 0, cycles = 0;

    always #25 clk = ~clk;

    comparator_control_and_wake dut (.clk(clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .raw_compare(raw_compare),
        .comparator_power(comparator_power),
        .noninv_ref_select(noninv_ref_select),
        .inverting_channel_select(inverting_channel_select),
        .pin_direction(pin_direction), .result_pin_out(result_pin_out),
        .result_pin_oe(result_pin_oe), .sleep_active(sleep_active),
        .wake_req(wake_req), .irq_vector_req(irq_vector_req), .irq(irq));
    cmp_analog_model ana (.noninv_ref_select(noninv_ref_select),
        .inverting_channel_select(inverting_channel_select),
        .ext_pos(ext_pos), .ref_level(ref_level), .neg_pin0(neg_pin0),
        .neg_pin1(neg_pin1), .raw_compare(raw_compare));

    // ************************************************************
    // Bus and compare tasks
    // ************************************************************
    // One access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_read <= ~w;
        avs_write <= w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    // Compare and report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time,
                     got, exp);
        end
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, e);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic end_of_test;
        if (n_errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            end_of_test;
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a <= 20; a += 4) rd(a[4:0], 32'h0);
        wr(OFS_CTL, 8'hFF);
        repeat (20) @(posedge clk);
        rd(OFS_CTL, 32'hF5);
        chk({comparator_power, noninv_ref_select, inverting_channel_select,
             result_pin_oe, result_pin_out}, 32'h1F);
        pin_direction <= 1'b1;
        @(posedge clk);
        chk(result_pin_oe, 32'h0);
        pin_direction <= 1'b0;
        wr(OFS_CTL, 8'h80);
        repeat (20) @(posedge clk);
        rd(OFS_CTL, 32'hC0);
        wr(OFS_FLAG, 8'h00);
        wr(OFS_STATUS, 8'h03);
        wr(OFS_IRQ_EN, 8'h03);
        wr(OFS_MASK, 8'h01);
        chk(irq, 32'h0);
        // Write with byte lane 0 off must be ignored
        avs_byteenable <= 4'hE;
        wr(OFS_MASK, 8'h00);
        avs_byteenable <= 4'hF;
        rd(OFS_MASK, 32'h1);
        neg_pin0 <= 40;
        repeat (10) @(posedge clk);
        rd(OFS_FLAG, 32'h1);
        rd(OFS_STATUS, 32'h1);
        chk(irq, 32'h1);
        wr(OFS_MASK, 8'h00);
        chk(irq, 32'h0);
        wr(OFS_STATUS, 8'h01);
        wr(OFS_MASK, 8'h01);
        chk(irq, 32'h0);
        wr(OFS_FLAG, 8'h00);
        repeat (10) @(posedge clk);
        rd(OFS_FLAG, 32'h0);
        rd(OFS_CTL, 32'h80);
        wr(OFS_FLAG, 8'h01);
        rd(OFS_FLAG, 32'h1);
        wr(OFS_FLAG, 8'h00);
        sleep_active <= 1'b1;
        neg_pin0 <= 5;
        repeat (10) @(posedge clk);
        chk(wake_req, 32'h1);
        chk(irq_vector_req, 32'h0);
        rd(OFS_STATUS, 32'h3);
        wr(OFS_IRQ_EN, 8'h07);
        chk(irq_vector_req, 32'h1);
        sleep_active <= 1'b0;
        // A control write refreshes the read latch, so a later flip flags
        wr(OFS_CTL, 8'h80);
        wr(OFS_FLAG, 8'h00);
        neg_pin0 <= 40;
        repeat (10) @(posedge clk);
        rd(OFS_FLAG, 32'h1);
        wr(OFS_CTL, 8'h20);
        repeat (5) @(posedge clk);
        rd(OFS_CTL, 32'h20);
        chk({comparator_power, result_pin_oe}, 32'h0);
        // Reset in mid-run with comparator and enables on
        wr(OFS_CTL, 8'hB5);
        wr(OFS_IRQ_EN, 8'h07);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({comparator_power, result_pin_oe, irq_vector_req, irq},
            32'h0);
        rd(OFS_CTL, 32'h00);
        end_of_test;
    end
endmodule
